// file: design/rgb_pwm_driver.sv
`timescale 1ns/1ps
// What this block does
// - Start frame and data frames travel most significant bit first.
// - Each serial bit is sampled on the rising edge of the shift clock.
// - First frame after the start frame belongs to the nearest chip.
// - A frame is a flag bit of one, then three 5-bit grey levels.
// - Map select high gives linear duty; low gives inverse-gamma, 256 grades.
// - Polarity select high drives active high; low inverts for external drive.
// - Source select low counts on shift clock; high on internal oscillator.
// - Incoming shift clock is regenerated and driven out for the next chip.
// - Serial data is re-driven on the data output for the next chip, with the own frame driven out as zeros.
// - The three outputs are pulse-width modulated from the held grey levels.
// - Shift register and grey counter are clocked independently only while source select is high.
module rgb_pwm_driver
  import rgb_pwm_pkg::*;
#(
  parameter int OSC_DIV = `OSC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // serial link in
  input wire logic shift_clock_in,
  input wire logic serial_data_in,
  // mode pins
  input wire logic grey_map_select,
  input wire logic output_polarity_select,
  input wire logic grey_clock_source_select,
  // serial link out
  output logic shift_clock_out,
  output logic serial_data_out,
  // led drive
  output logic [2:0] channel_outputs
);
  generate
    if (OSC_DIV < 2 || OSC_DIV > 256) begin : g_bad_div
      $error("OSC_DIV must lie between 2 and 256");
    end
  endgenerate

  // two-flop synchronisers for the serial and mode pins; reset is used unsynchronised
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic clk_prev;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {shift_clock_in, serial_data_in, grey_map_select,
                   output_polarity_select, grey_clock_source_select};
      pin_sync <= pin_meta;
    end
  end

  wire clk_s = pin_sync[4];
  wire data_s = pin_sync[3];
  pin_mode_t mode;
  assign mode = pin_sync[2:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  // sync delays clock and data equally, so setup at the pin is kept
  wire shift_rise = clk_s & ~clk_prev;
  wire bit_in = data_s;

  // frame parser
  link_state_t state;
  link_state_t next_state;
  logic [`ZERO_CNT_BITS-1:0] zero_cnt;
  logic [`BIT_CNT_BITS-1:0] bit_cnt;
  logic [`FRAME_PAYLOAD_BITS-1:0] payload;
  grey_frame_t pending;
  grey_frame_t holding;
  logic pending_valid;

  wire start_seen = zero_cnt >= `START_ZERO_BITS;
  wire flag_now = (state == HUNT_START) && shift_rise && bit_in && start_seen;
  // bit_cnt holds the payload bits already taken, so the last one arrives at fourteen
  wire own_done = (state == TAKE_OWN) && shift_rise &&
                  (bit_cnt == `FRAME_PAYLOAD_BITS - 5'h01);
  wire restart = (state == PASS_ON) && shift_rise && !bit_in &&
                 (zero_cnt == `START_ZERO_BITS - 6'h01);
  wire [`FRAME_PAYLOAD_BITS-1:0] next_payload = {payload[13:0], bit_in};
  wire apply_now = (state == PASS_ON) && shift_rise && pending_valid;
  // own frame goes out as zeros, which only lengthens the start frame downstream
  wire out_bit = ((state == TAKE_OWN) || flag_now) ? 1'b0 : bit_in;

  always_comb begin
    next_state = state;
    case (state)
      HUNT_START: if (flag_now) next_state = TAKE_OWN;
      TAKE_OWN: if (own_done) next_state = PASS_ON;
      PASS_ON: if (restart) next_state = HUNT_START;
      default: next_state = HUNT_START;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= HUNT_START;
      zero_cnt <= 6'h00;
    end else begin
      state <= next_state;
      if (shift_rise) begin
        if (bit_in) zero_cnt <= 6'h00;
        else if (!start_seen) zero_cnt <= zero_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bit_cnt <= 5'h00;
      payload <= 15'h0000;
    end else if (flag_now) begin
      bit_cnt <= 5'h00;
    end else if ((state == TAKE_OWN) && shift_rise) begin
      bit_cnt <= bit_cnt + 5'h01;
      payload <= next_payload;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pending <= '0;
      pending_valid <= 1'b0;
      holding <= '0;
    end else begin
      if (own_done) begin
        pending <= next_payload;
        pending_valid <= 1'b1;
      end else if (apply_now) begin
        pending_valid <= 1'b0;
      end
      if (apply_now) holding <= pending;
    end
  end

  // outputs to the next chip: data moves on the detected edge, clock follows one
  // cycle later so downstream always sees settled data at its rising edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      serial_data_out <= 1'b0;
      shift_clock_out <= 1'b0;
    end else begin
      if (shift_rise) serial_data_out <= out_bit;
      shift_clock_out <= clk_prev;
    end
  end

  // grey counter, on the oscillator tick or on the shift clock edge as source select picks
  logic [7:0] osc_cnt;
  logic osc_tick;
  duty_t grey_count;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else if (osc_cnt == 8'(OSC_DIV - 1)) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
      osc_tick <= 1'b0;
    end
  end

  // on the shift clock the outputs only move while the sender clocks
  wire grey_tick = mode.grey_clock_source_select ? osc_tick : shift_rise;

  always_ff @(posedge core_clk) begin
    if (reset) grey_count <= `DUTY_RESET;
    else if (grey_tick) grey_count <= grey_count + 8'h01;
  end

  wire grey_t levels [3] = '{holding.ch0, holding.ch1, holding.ch2};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_ch
      pwm_channel u_channel (
        .core_clk(core_clk),
        .reset(reset),
        .grey_level(levels[ch]),
        .mode(mode),
        .grey_count(grey_count),
        .channel_output(channel_outputs[ch])
      );
    end
  endgenerate

  a_hunt_needs_zeros: assert property (@(posedge core_clk) disable iff (reset)
    (state == HUNT_START) && shift_rise && bit_in && !start_seen |=>
    (state == HUNT_START))
    else $error("frame taken without a full start frame");

  a_own_frame_len: assert property (@(posedge core_clk) disable iff (reset)
    (state == TAKE_OWN) |-> bit_cnt < `FRAME_PAYLOAD_BITS)
    else $error("own frame longer than fifteen payload bits");

  a_own_muted: assert property (@(posedge core_clk) disable iff (reset)
    (state == TAKE_OWN) && shift_rise |=> !serial_data_out)
    else $error("own frame leaked downstream");

  a_pass_copy: assert property (@(posedge core_clk) disable iff (reset)
    (state == PASS_ON) && shift_rise |=> serial_data_out == $past(bit_in))
    else $error("passed bit differs from received bit");

  a_clock_regen: assert property (@(posedge core_clk) disable iff (reset)
    shift_rise |=> !shift_clock_out ##1 shift_clock_out)
    else $error("clock out does not follow clock in");

  a_capture_order: assert property (@(posedge core_clk) disable iff (reset)
    own_done |=> pending.ch2[0] == $past(bit_in) && pending_valid)
    else $error("last payload bit not at channel two lsb");

  a_hold_apply: assert property (@(posedge core_clk) disable iff (reset)
    apply_now |=> holding == $past(pending) && !pending_valid)
    else $error("pending grey data not applied");

  a_hold_stable: assert property (@(posedge core_clk) disable iff (reset)
    !apply_now |=> $stable(holding))
    else $error("grey data changed without trailing pulse");

  a_count_step: assert property (@(posedge core_clk) disable iff (reset)
    grey_tick |=> grey_count == 8'($past(grey_count) + 8'h01))
    else $error("grey counter missed a tick");

  a_count_source: assert property (@(posedge core_clk) disable iff (reset)
    !mode.grey_clock_source_select && !shift_rise |=> $stable(grey_count))
    else $error("grey counter moved without a shift clock edge");

  c_own_taken: cover property (@(posedge core_clk) disable iff (reset) own_done);
  c_hold_applied: cover property (@(posedge core_clk) disable iff (reset) apply_now);
  c_restart: cover property (@(posedge core_clk) disable iff (reset) restart);
  c_free_run: cover property (@(posedge core_clk) disable iff (reset)
    mode.grey_clock_source_select && osc_tick && channel_outputs[0]);
endmodule

// file: design/rgb_pwm_map.svh
`ifndef RGB_PWM_MAP_SVH
`define RGB_PWM_MAP_SVH

// serial framing
`define START_ZERO_BITS 6'h20
`define ZERO_CNT_BITS 6
`define FRAME_BITS 5'h10
`define FRAME_PAYLOAD_BITS 5'h0F
`define BIT_CNT_BITS 5

// field positions inside the 15-bit payload, most significant first
`define CH0_MSB 14
`define CH0_LSB 10
`define CH1_MSB 9
`define CH1_LSB 5
`define CH2_MSB 4
`define CH2_LSB 0

// grey-level widths
`define GREY_BITS 5
`define DUTY_BITS 8

// free-running oscillator divider from core_clk
`define OSC_DIV_DEFAULT 4

// reset values
`define GREY_RESET 5'h00
`define DUTY_RESET 8'h00

`endif

// file: design/rgb_pwm_pkg.sv
package rgb_pwm_pkg;
  `include "rgb_pwm_map.svh"

  typedef logic [`GREY_BITS-1:0] grey_t;
  typedef logic [`DUTY_BITS-1:0] duty_t;

  typedef struct packed {
    grey_t ch0;
    grey_t ch1;
    grey_t ch2;
  } grey_frame_t;

  typedef struct packed {
    logic grey_map_select;
    logic output_polarity_select;
    logic grey_clock_source_select;
  } pin_mode_t;

  typedef enum logic [1:0] {
    HUNT_START,
    TAKE_OWN,
    PASS_ON
  } link_state_t;
endpackage

// file: design/pwm_channel.sv
`timescale 1ns/1ps
module pwm_channel
  import rgb_pwm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // level and mode
  input wire grey_t grey_level,
  input wire pin_mode_t mode,
  input wire duty_t grey_count,
  // drive
  output logic channel_output
);
  logic [9:0] square;
  duty_t linear_duty;
  duty_t gamma_duty;
  duty_t duty;
  logic active;

  // replicate top bits so full scale reaches 255
  assign linear_duty = {grey_level, grey_level[4:2]};
  // square law gives the inverse-gamma curve over 256 grades
  assign square = 10'(grey_level) * 10'(grey_level);
  assign gamma_duty = square[9:2];
  assign duty = mode.grey_map_select ? linear_duty : gamma_duty;
  assign active = grey_count < duty;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      channel_output <= 1'b0;
    end else begin
      channel_output <= mode.output_polarity_select ? active : ~active;
    end
  end

  a_pwm_level: assert property (@(posedge core_clk) disable iff (reset)
    (grey_count < duty) && mode.output_polarity_select |=> channel_output)
    else $error("channel not active while count below duty");

  a_pwm_invert: assert property (@(posedge core_clk) disable iff (reset)
    !(grey_count < duty) && !mode.output_polarity_select |=> channel_output)
    else $error("inverted polarity not driven during off phase");
endmodule

// file: test/link_sender.sv
`timescale 1ns/1ps
module link_sender (
  // serial link towards the driver
  output logic shift_clock_in,
  output logic serial_data_in
);
  // clock rests low between frames; released data floats to its pull-up
  initial begin
    shift_clock_in = 1'b0;
    serial_data_in = 1'b1;
  end
  // 320 ns per bit, data set 80 ns before the rise and held 240 ns after it
  task automatic send_bit(input logic b);
    serial_data_in = b;
    #80;
    shift_clock_in = 1'b1;
    #160;
    shift_clock_in = 1'b0;
    #80;
  endtask
  task automatic send_word(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      send_bit(w[i]);
    end
  endtask
  task automatic release_line();
    serial_data_in = 1'b1;
  endtask
endmodule

// file: test/rgb_pwm_driver_bench.sv
`timescale 1ns/1ps
module rgb_pwm_driver_bench;
  import rgb_pwm_pkg::*;
  // short divider keeps one pwm period at 512 cycles
  localparam int DIV = 2;
  logic core_clk, reset, shift_clock_in, serial_data_in;
  logic grey_map_select, output_polarity_select, grey_clock_source_select;
  logic shift_clock_out, serial_data_out;
  logic [2:0] channel_outputs;
  logic [2:0] held;
  logic [31:0] fwd_bits = 32'h0;
  logic [31:0] r;
  int err_total = 0;
  int n_checks = 0;
  int fwd_count = 0;
  int start_count, chg;
  grey_frame_t own;
  logic [15:0] down;

  rgb_pwm_driver #(.OSC_DIV(DIV)) uut (
    .core_clk(core_clk), .reset(reset),
    .shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in),
    .grey_map_select(grey_map_select), .output_polarity_select(output_polarity_select),
    .grey_clock_source_select(grey_clock_source_select),
    .shift_clock_out(shift_clock_out), .serial_data_out(serial_data_out),
    .channel_outputs(channel_outputs)
  );
  link_sender far_end (.shift_clock_in(shift_clock_in), .serial_data_in(serial_data_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // what the next chip would shift in
  always @(posedge shift_clock_out) begin
    fwd_bits <= {fwd_bits[30:0], serial_data_out};
    fwd_count <= fwd_count + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] duty_of(input logic [4:0] v, input logic lin);
    logic [9:0] sq;
    sq = v * v;
    return lin ? {v, v[4:2]} : sq[9:2];
  endfunction

  task automatic send_update(input grey_frame_t f, input logic with_down);
    far_end.send_word(16'h0000, 16);
    far_end.send_word(16'h0000, 16);
    far_end.send_word({1'b1, f}, 16);
    if (with_down) far_end.send_word(down, 16);
    far_end.release_line();
    repeat (8) @(posedge core_clk);
  endtask

  // one full period per mode, high time counted per channel
  task automatic measure(input grey_frame_t f);
    int hi [3];
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      #1;
      grey_map_select = m[0];
      output_polarity_select = m[1];
      repeat (10) @(posedge core_clk);
      hi = '{0, 0, 0};
      repeat (256 * DIV) begin
        @(posedge core_clk);
        #1;
        for (int c = 0; c < 3; c++) hi[c] += (channel_outputs[c] === 1'b1);
      end
      for (int c = 0; c < 3; c++) begin
        d = duty_of(c == 0 ? f.ch0 : (c == 1 ? f.ch1 : f.ch2), m[0]);
        check("channel high cycles", hi[c], m[1] ? d * DIV : (256 - d) * DIV);
      end
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #4000000;
    err_total++;
    results();
  end

  initial begin
    reset = 1'b1;
    grey_map_select = 1'b1;
    output_polarity_select = 1'b1;
    grey_clock_source_select = 1'b1;
    void'($urandom(99712));
    repeat (5) @(posedge core_clk);
    #1;
    check("outputs in reset", channel_outputs, 3'h0);
    reset = 1'b0;
    // stray ones before any start frame must not be taken as a flag
    far_end.send_word(16'h00FF, 16);
    // corner levels; no append pulse yet, so the old zero levels must stay
    own = '{5'h1F, 5'h00, 5'h10};
    send_update(own, 1'b0);
    measure(15'h0000);
    far_end.send_bit(1'b0);
    far_end.release_line();
    measure(own);
    // counter fed by the still link clock must freeze the outputs
    grey_clock_source_select = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    held = channel_outputs;
    chg = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1;
      chg += (channel_outputs !== held);
    end
    check("outputs with still link clock", chg, 0);
    grey_clock_source_select = 1'b1;
    for (int u = 0; u < 2; u++) begin
      r = $urandom();
      own = r[14:0];
      down = {1'b1, r[30:16]};
      start_count = fwd_count;
      send_update(own, 1'b1);
      check("forwarded clock rises", fwd_count - start_count, 64);
      check("own frame on output", fwd_bits[31:16], 16'h0000);
      check("downstream frame", fwd_bits[15:0], down);
      measure(own);
    end
    results();
  end
endmodule
